// [bench/ccr_top_assertions.sv]
// Checker of the port relations of the configuration bank.
`default_nettype none
module ccr_top_checker
	import ccr_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic link_mode_single,
	input wire logic [15:0] fullscale_b_setting,
	input wire logic [3*CCR_LANES-1:0] lane_preemphasis_level,
	input wire logic [CCR_LANES-1:0] lane_preemphasis_extra,
	input wire logic cal_run,
	input wire logic cal_reset_n,
	input wire logic divider_reset_n,
	input wire logic chan_a_from_b,
	input wire logic chan_b_from_a,
	input wire logic single_src_a,
	input wire logic single_src_b,
	input wire logic single_src_both
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wr_fs_r;
	logic [2:0] src;
	assign src = {single_src_a, single_src_b, single_src_both};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_fs_r <= 4'h0;
		end else begin
			wr_fs_r <= {wr_fs_r[2:0], hsel & hready & htrans[1] & hwrite & (haddr[9:2] == CCR_IDX_FS_B)};
		end
	end
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// ==========================================================
	// Assertions.
	property p_fs; $changed(fullscale_b_setting) |-> |wr_fs_r; endproperty
	a_fs: assert property (p_fs) else $error("range changed without a write");
	property p_lanes; lane_preemphasis_level == {CCR_LANES{lane_preemphasis_level[2:0]}}; endproperty
	a_lanes: assert property (p_lanes) else $error("lane levels differ");
	property p_extra; lane_preemphasis_extra == {CCR_LANES{lane_preemphasis_extra[0]}}; endproperty
	a_extra: assert property (p_extra) else $error("lane boosts differ");
	property p_cal; cal_reset_n == cal_run; endproperty
	a_cal: assert property (p_cal) else $error("calibration reset mismatch");
	property p_div; $fell(cal_run) |-> !divider_reset_n; endproperty
	a_div: assert property (p_div) else $error("dividers not reset");
	property p_swap; chan_a_from_b == chan_b_from_a; endproperty
	a_swap: assert property (p_swap) else $error("swap halves differ");
	property p_src; $onehot0(src); endproperty
	a_src: assert property (p_src) else $error("single source not one-hot");
	property p_mode; !(chan_a_from_b && (src != 3'h0)); endproperty
	a_mode: assert property (p_mode) else $error("single and dual both applied");
	// The slave only turns ready on the first edge after reset is released.
	property p_okay; $past(hresetn) |-> hreadyout && !hresp; endproperty
	a_okay: assert property (p_okay) else $error("bus not ready or not okay");
	c_calclr: cover property ($fell(cal_run));
	c_swap: cover property (chan_a_from_b);
	c_both: cover property (single_src_both);
endmodule
bind ccr_top ccr_top_checker u_ccr_top_checker(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hready, .hreadyout, .hresp, .link_mode_single, .fullscale_b_setting, .lane_preemphasis_level,
	.lane_preemphasis_extra, .cal_run, .cal_reset_n, .divider_reset_n, .chan_a_from_b,
	.chan_b_from_a, .single_src_a, .single_src_b, .single_src_both);
`default_nettype wire

// [bench/converter_config_regs_tb.sv]
// Self-checking bench of the configuration bank.
`default_nettype none
module converter_config_regs_tb;
	import ccr_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, mode = 1, link_en = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
	logic [1:0] htrans = 0;
	wire logic hready;
	logic hresp, rb, ts, pm, cr, crn, dr, ab, ba, sa, sb, sab;
	logic [15:0] fs, ex;
	logic [47:0] lv;
	int fail_count = 0, checks_done = 0, cyc = 0;
	typedef struct {logic [7:0] i; logic w; logic [31:0] d, e;} ccr_row_t;
	ccr_row_t rows[11] = '{'{CCR_IDX_FS_B, 0, 0, 32'ha000}, '{CCR_IDX_REF_BYP, 0, 0, 0},
		'{CCR_IDX_TSTAMP, 0, 0, 0}, '{CCR_IDX_PREEMPH, 0, 0, 0}, '{CCR_IDX_INSEL, 0, 0, 1},
		'{CCR_IDX_CALRUN, 0, 0, 1}, '{CCR_IDX_FS_B, 1, 32'hffff, 32'hffff},
		'{CCR_IDX_REF_BYP, 1, '1, 32'hff}, '{CCR_IDX_TSTAMP, 1, 3, 3},
		'{CCR_IDX_PREEMPH, 1, 32'hd, 32'hd}, '{8'h40, 1, '1, 0}};
	ccr_top u_ccr_top(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready, .hrdata, .hreadyout(hready), .hresp, .link_mode_single(mode),
		.serial_link_enable(link_en), .fullscale_b_setting(fs), .reference_source_bypass(rb),
		.timestamp_receiver_on(ts), .timestamp_pecl_mode(pm), .lane_preemphasis_level(lv),
		.lane_preemphasis_extra(ex), .cal_run(cr), .cal_reset_n(crn), .divider_reset_n(dr),
		.chan_a_from_b(ab), .chan_b_from_a(ba), .single_src_a(sa), .single_src_b(sb),
		.single_src_both(sab));
	initial begin
		forever #12.5 hclk = ~hclk;
	end
	task automatic chk(input string n, input logic [47:0] g, e);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic bus(input logic [7:0] i, input logic w, input logic [31:0] d);
		hsel <= 1;
		htrans <= 2'h2;
		haddr <= {22'h0, i, 2'h0};
		hwrite <= w;
		do @(posedge hclk); while (hready !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		q = hrdata;
	endtask
	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		bus(i, 1, d);
		repeat (3) @(posedge hclk);
	endtask
	task automatic recal();
		wr(CCR_IDX_CALRUN, 0);
		wr(CCR_IDX_CALRUN, 1);
	endtask
	task automatic give_verdict();
		if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	always @(posedge hclk) begin
		cyc++;
		if (cyc == 20000) begin
			fail_count++;
			give_verdict();
		end
	end
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1;
		repeat (2) @(posedge hclk);
		foreach (rows[k]) begin
			if (rows[k].w) bus(rows[k].i, 1, rows[k].d);
			bus(rows[k].i, 0, 0);
			chk("readback", q, rows[k].e);
		end
		chk("range", fs, 16'hffff);
		chk("bypass", rb, 1);
		chk("ts_on", ts, 1);
		chk("pecl", pm, 1);
		chk("level", lv, {16{3'h5}});
		chk("boost", ex, 16'hffff);
		wr(CCR_IDX_INSEL, 2);
		chk("src_a", sa, 1);
		wr(CCR_IDX_CALRUN, 0);
		chk("cal", {cr, crn}, 0);
		chk("div", dr, 0);
		wr(CCR_IDX_CALRUN, 1);
		chk("src_b", {sa, sb, dr}, 3'h3);
		wr(CCR_IDX_INSEL, 32'h13);
		recal();
		mode <= 0;
		repeat (3) @(posedge hclk);
		chk("dual", {ab, ba, sa, sb, sab}, 5'h18);
		mode <= 1;
		repeat (3) @(posedge hclk);
		chk("both", {ab, sab}, 2'h1);
		link_en <= 1;
		bus(CCR_IDX_STATUS, 0, 0);
		chk("seq_ok", q, 32'h3);
		wr(CCR_IDX_CALRUN, 0);
		bus(CCR_IDX_STATUS, 0, 0);
		chk("seq_err", q, 32'h6);
		link_en <= 0;
		wr(CCR_IDX_STATUS, 32'h4);
		bus(CCR_IDX_STATUS, 0, 0);
		chk("seq_clr", q, 32'h2);
		wr(CCR_IDX_CALRUN, 1);
		wr(CCR_IDX_INSEL, 0);
		recal();
		chk("rsvd", {sa, sb, sab}, 0);
		hresetn <= 0;
		@(posedge hclk);
		chk("rst", {fs, cr}, {16'ha000, 1'b1});
		hresetn <= 1;
		repeat (2) @(posedge hclk);
		give_verdict();
	end
endmodule
`default_nettype wire

// [src/ccr_field_reg.sv]
// One software-writable register field with a reset value.
`default_nettype none
module ccr_field_reg #(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic wr_en,
	input wire logic [WIDTH-1:0] wr_data,
	output logic [WIDTH-1:0] value_r
);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			value_r <= RESET_VAL;
		end else if (wr_en) begin
			value_r <= wr_data;
		end
	end
endmodule
`default_nettype wire

// [src/ccr_pkg.sv]
// Package of offsets, reset values and field positions for the converter configuration bank.
`default_nettype none
package ccr_pkg;
	// ==========================================================
	// Register indices as printed; byte address is four times the index.
	localparam logic [7:0] CCR_IDX_FS_B = 8'h32;
	localparam logic [7:0] CCR_IDX_REF_BYP = 8'h38;
	localparam logic [7:0] CCR_IDX_TSTAMP = 8'h3b;
	localparam logic [7:0] CCR_IDX_PREEMPH = 8'h48;
	localparam logic [7:0] CCR_IDX_INSEL = 8'h60;
	localparam logic [7:0] CCR_IDX_CALRUN = 8'h61;
	localparam logic [7:0] CCR_IDX_STATUS = 8'h70;
	// ==========================================================
	// Reset values.
	localparam logic [15:0] CCR_RST_FS_B = 16'ha000;
	localparam logic [7:0] CCR_RST_REF_BYP = 8'h00;
	localparam logic [7:0] CCR_RST_TSTAMP = 8'h00;
	localparam logic [7:0] CCR_RST_PREEMPH = 8'h00;
	localparam logic [7:0] CCR_RST_INSEL = 8'h01;
	localparam logic [7:0] CCR_RST_CALRUN = 8'h01;
	// ==========================================================
	// Field positions.
	localparam int CCR_BIT_REF_BYP = 0;
	localparam int CCR_BIT_TS_RECV = 0;
	localparam int CCR_BIT_TS_PECL = 1;
	localparam int CCR_BIT_PE_BOOST = 3;
	localparam int CCR_BIT_DUAL_SWAP = 4;
	localparam int CCR_BIT_CALRUN = 0;
	localparam int CCR_LANES = 16;
	// ==========================================================
	// Single-channel source codes.
	localparam logic [1:0] CCR_SRC_RSVD = 2'h0;
	localparam logic [1:0] CCR_SRC_A = 2'h1;
	localparam logic [1:0] CCR_SRC_B = 2'h2;
	localparam logic [1:0] CCR_SRC_AB = 2'h3;
	// ==========================================================
	// Write-phase states of the bus slave.
	typedef enum logic [1:0] {
		CCR_ST_IDLE = 2'b01,
		CCR_ST_WDATA = 2'b10
	} ccr_state_t;
endpackage
`default_nettype wire

// [src/ccr_top.sv]
// Converter configuration register bank with an AHB-Lite slave port.
//
// Decided for this implementation: the AHB-Lite slave port.
`default_nettype none
module ccr_top
	import ccr_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic link_mode_single,
	input wire logic serial_link_enable,
	output logic [15:0] fullscale_b_setting,
	output logic reference_source_bypass,
	output logic timestamp_receiver_on,
	output logic timestamp_pecl_mode,
	output logic [3*CCR_LANES-1:0] lane_preemphasis_level,
	output logic [CCR_LANES-1:0] lane_preemphasis_extra,
	output logic cal_run,
	output logic cal_reset_n,
	output logic divider_reset_n,
	output logic chan_a_from_b,
	output logic chan_b_from_a,
	output logic single_src_a,
	output logic single_src_b,
	output logic single_src_both
);
	// ==========================================================
	// Bus slave.
	ccr_state_t state_r;
	logic [7:0] widx_r;
	logic [7:0] ridx;
	logic take;
	logic [15:0] fs_b_q;
	logic [7:0] ref_q;
	logic [7:0] ts_q;
	logic [7:0] pe_q;
	logic [7:0] insel_q;
	logic [7:0] cal_q;
	logic wr_phase;
	logic [31:0] rd_nxt;
	logic seq_err_r;

	assign take = hsel && hready && htrans[1];
	assign ridx = haddr[9:2];
	assign wr_phase = (state_r == CCR_ST_WDATA);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= CCR_ST_IDLE;
			widx_r <= 8'h00;
		end else if (take && hwrite) begin
			state_r <= CCR_ST_WDATA;
			widx_r <= ridx;
		end else if (hready) begin
			state_r <= CCR_ST_IDLE;
		end
	end

	always_comb begin
		rd_nxt = 32'h0000_0000;
		if (ridx == CCR_IDX_FS_B) begin
			rd_nxt = {16'h0000, fs_b_q};
		end else if (ridx == CCR_IDX_REF_BYP) begin
			rd_nxt = {24'h000000, ref_q};
		end else if (ridx == CCR_IDX_TSTAMP) begin
			rd_nxt = {24'h000000, ts_q};
		end else if (ridx == CCR_IDX_PREEMPH) begin
			rd_nxt = {24'h000000, pe_q};
		end else if (ridx == CCR_IDX_INSEL) begin
			rd_nxt = {24'h000000, insel_q};
		end else if (ridx == CCR_IDX_CALRUN) begin
			rd_nxt = {24'h000000, cal_q};
		end else if (ridx == CCR_IDX_STATUS) begin
			rd_nxt = {29'h0000_0000, seq_err_r, link_mode_single, cal_run};
		end
	end

	// Read data is registered from the address phase; every access has zero wait states.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (take && !hwrite) begin
			hrdata <= rd_nxt;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hreadyout <= 1'b0;
			hresp <= 1'b0;
		end else begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// ==========================================================
	// Register storage, byte-wide except the full-scale word.
	ccr_field_reg #(.WIDTH(16), .RESET_VAL(CCR_RST_FS_B)) u_fs_b (
		.hclk(hclk), .hresetn(hresetn),
		.wr_en(wr_phase && widx_r == CCR_IDX_FS_B),
		.wr_data(hwdata[15:0]), .value_r(fs_b_q));
	ccr_field_reg #(.WIDTH(8), .RESET_VAL(CCR_RST_REF_BYP)) u_ref (
		.hclk(hclk), .hresetn(hresetn),
		.wr_en(wr_phase && widx_r == CCR_IDX_REF_BYP),
		.wr_data(hwdata[7:0]), .value_r(ref_q));
	ccr_field_reg #(.WIDTH(8), .RESET_VAL(CCR_RST_TSTAMP)) u_ts (
		.hclk(hclk), .hresetn(hresetn),
		.wr_en(wr_phase && widx_r == CCR_IDX_TSTAMP),
		.wr_data(hwdata[7:0]), .value_r(ts_q));
	ccr_field_reg #(.WIDTH(8), .RESET_VAL(CCR_RST_PREEMPH)) u_pe (
		.hclk(hclk), .hresetn(hresetn),
		.wr_en(wr_phase && widx_r == CCR_IDX_PREEMPH),
		.wr_data(hwdata[7:0]), .value_r(pe_q));
	ccr_field_reg #(.WIDTH(8), .RESET_VAL(CCR_RST_INSEL)) u_insel (
		.hclk(hclk), .hresetn(hresetn),
		.wr_en(wr_phase && widx_r == CCR_IDX_INSEL),
		.wr_data(hwdata[7:0]), .value_r(insel_q));
	ccr_field_reg #(.WIDTH(8), .RESET_VAL(CCR_RST_CALRUN)) u_cal (
		.hclk(hclk), .hresetn(hresetn),
		.wr_en(wr_phase && widx_r == CCR_IDX_CALRUN),
		.wr_data(hwdata[7:0]), .value_r(cal_q));

	// ==========================================================
	// Sticky flag: calibration-run cleared while the link is enabled; a status write with bit 2 set clears it only while that condition is absent.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			seq_err_r <= 1'b0;
		end else if (!cal_q[CCR_BIT_CALRUN] && serial_link_enable) begin
			seq_err_r <= 1'b1;
		end else if (wr_phase && widx_r == CCR_IDX_STATUS && hwdata[2]) begin
			seq_err_r <= 1'b0;
		end
	end

	// ==========================================================
	// Calibration control and the input selection that it latches.
	logic [7:0] insel_act_r;
	logic cal_prev_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cal_run <= 1'b1;
			cal_reset_n <= 1'b1;
			divider_reset_n <= 1'b1;
			cal_prev_r <= 1'b1;
		end else begin
			cal_run <= cal_q[CCR_BIT_CALRUN];
			cal_reset_n <= cal_q[CCR_BIT_CALRUN];
			divider_reset_n <= cal_q[CCR_BIT_CALRUN];
			cal_prev_r <= cal_q[CCR_BIT_CALRUN];
		end
	end

	// The new selection reaches the mux only when a calibration starts.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			insel_act_r <= CCR_RST_INSEL;
		end else if (cal_q[CCR_BIT_CALRUN] && !cal_prev_r) begin
			insel_act_r <= insel_q;
		end
	end

	// ==========================================================
	// Analog and serializer control outputs.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			fullscale_b_setting <= CCR_RST_FS_B;
			reference_source_bypass <= 1'b0;
			timestamp_receiver_on <= 1'b0;
			timestamp_pecl_mode <= 1'b0;
			lane_preemphasis_level <= '0;
			lane_preemphasis_extra <= '0;
		end else begin
			fullscale_b_setting <= fs_b_q;
			reference_source_bypass <= ref_q[CCR_BIT_REF_BYP];
			timestamp_receiver_on <= ts_q[CCR_BIT_TS_RECV];
			timestamp_pecl_mode <= ts_q[CCR_BIT_TS_PECL];
			lane_preemphasis_level <= {CCR_LANES{pe_q[2:0]}};
			lane_preemphasis_extra <= {CCR_LANES{pe_q[CCR_BIT_PE_BOOST]}};
		end
	end

	// ==========================================================
	// Input routing by link mode.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			chan_a_from_b <= 1'b0;
			chan_b_from_a <= 1'b0;
			single_src_a <= 1'b0;
			single_src_b <= 1'b0;
			single_src_both <= 1'b0;
		end else if (link_mode_single) begin
			chan_a_from_b <= 1'b0;
			chan_b_from_a <= 1'b0;
			single_src_a <= (insel_act_r[1:0] == CCR_SRC_A);
			single_src_b <= (insel_act_r[1:0] == CCR_SRC_B);
			single_src_both <= (insel_act_r[1:0] == CCR_SRC_AB);
		end else begin
			chan_a_from_b <= insel_act_r[CCR_BIT_DUAL_SWAP];
			chan_b_from_a <= insel_act_r[CCR_BIT_DUAL_SWAP];
			single_src_a <= 1'b0;
			single_src_b <= 1'b0;
			single_src_both <= 1'b0;
		end
	end
endmodule
`default_nettype wire
